// ==== include/clcfg_consts.vh ====
`ifndef CLCFG_CONSTS_VH
`define CLCFG_CONSTS_VH
// =====================================================
// register map
`define CLCFG_ADDR_W 8
`define CLCFG_OFF_CFG1 8'h88
`define CLCFG_OFF_STATUS 8'h90
`define CLCFG_RESET_VAL 32'h00000000
// =====================================================
// field positions
`define CLCFG_ACC_HI 29
`define CLCFG_ACC_LO 25
`define CLCFG_SRC_BIT 24
`define CLCFG_DEC_HI 23
`define CLCFG_DEC_LO 19
`define CLCFG_FREQ_HI 18
`define CLCFG_FREQ_LO 15
`define CLCFG_MOD_BIT 14
`define CLCFG_TSEL_HI 13
`define CLCFG_TSEL_LO 12
`define CLCFG_TDIV_HI 11
`define CLCFG_TDIV_LO 8
`define CLCFG_TPOL_BIT 7
`define CLCFG_BEMF_HI 6
`define CLCFG_BEMF_LO 4
`define CLCFG_SURGE_BIT 3
`define CLCFG_DTC_BIT 2
`define CLCFG_VLD_BIT 1
`define CLCFG_BRK_BIT 0
// =====================================================
// codes and limits
`define CLCFG_RATE_UNLIM 5'h1F
`define CLCFG_FREQ_MAX 4'hD
`define CLCFG_FREQ_BASE 8'h0A
`define CLCFG_FREQ_STEP 8'h05
`define CLCFG_TSEL_BAD 2'h3
`define CLCFG_BEMF_MAX 3'h5
`define CLCFG_STOP_RECIRC 3'h1
`define CLCFG_RESP_OKAY 2'h0
`define CLCFG_RESP_SLVERR 2'h2
`endif

// ==== src/clcfg_rate_lut.v ====
`timescale 1ns/1ps
`include "clcfg_consts.vh"
// =====================================================
// rate code to rate in tenths of hz/s, zero means no limit
module clcfg_rate_lut (
  input wire [4:0] code,
  output reg [19:0] rate_x10,
  output wire unlimited
);
  assign unlimited = (code == `CLCFG_RATE_UNLIM);
  always @* begin
    case (code)
      5'h00: rate_x10 = 20'h00005;
      5'h01: rate_x10 = 20'h0000A;
      5'h02: rate_x10 = 20'h00019;
      5'h03: rate_x10 = 20'h00032;
      5'h04: rate_x10 = 20'h0004B;
      5'h05: rate_x10 = 20'h00064;
      5'h06: rate_x10 = 20'h000C8;
      5'h07: rate_x10 = 20'h00190;
      5'h08: rate_x10 = 20'h00258;
      5'h09: rate_x10 = 20'h00320;
      5'h0A: rate_x10 = 20'h003E8;
      5'h0B: rate_x10 = 20'h007D0;
      5'h0C: rate_x10 = 20'h00BB8;
      5'h0D: rate_x10 = 20'h00FA0;
      5'h0E: rate_x10 = 20'h01388;
      5'h0F: rate_x10 = 20'h01770;
      5'h10: rate_x10 = 20'h01B58;
      5'h11: rate_x10 = 20'h01F40;
      5'h12: rate_x10 = 20'h02328;
      5'h13: rate_x10 = 20'h02710;
      5'h14: rate_x10 = 20'h04E20;
      5'h15: rate_x10 = 20'h09C40;
      5'h16: rate_x10 = 20'h0EA60;
      5'h17: rate_x10 = 20'h13880;
      5'h18: rate_x10 = 20'h186A0;
      5'h19: rate_x10 = 20'h30D40;
      5'h1A: rate_x10 = 20'h493E0;
      5'h1B: rate_x10 = 20'h61A80;
      5'h1C: rate_x10 = 20'h7A120;
      5'h1D: rate_x10 = 20'h927C0;
      5'h1E: rate_x10 = 20'hAAE60;
      default: rate_x10 = 20'h00000;
    endcase
  end
endmodule // clcfg_rate_lut

// ==== src/clcfg_top.v ====
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "clcfg_consts.vh"
// What this block does
// - decode deceleration rate code, 1Fh unlimited
// - decel field used only without surge, source zero
// - switching frequency 10 to 75 kHz, E/F reserved
// - bit 14 selects continuous or discontinuous modulation
// - tach output phase select, code 3 undefined
// - tach divider, codes 0 and 1 divide by one
// - tach stops below back-emf cutoff when bit set
// - back-emf cutoff 1 to 30 mV, 6/7 reserved
// - bit 3 enables surge protection
// - bit 2 enables dead-time compensation
// - bit 1 bypasses velocity loop
// - slow recirc stop: hi-z or low-side brake
// - bit 24 picks decel or accel field for decel
module clcfg_top (
  input wire mclk,
  input wire rst_n,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [2:0] stop_mode,
  input wire slow_phase,
  input wire closed_loop_phase,
  input wire first_attempt,
  input wire motor_driven,
  input wire backemf_low,
  output reg [19:0] decel_rate_x10,
  output reg decel_unlimited,
  output reg [7:0] output_switching_freq_khz,
  output reg freq_reserved,
  output reg discontinuous_svm,
  output reg tach_enable,
  output reg [3:0] tach_divide_by,
  output reg [5:0] tach_backemf_cutoff_mv,
  output reg cutoff_reserved,
  output reg surge_protect_enable,
  output reg deadtime_comp_enable,
  output reg velocity_loop_run,
  output reg outputs_hiz,
  output reg low_side_brake
);
  // =====================================================
  // storage
  reg [31:0] cfg_q;
  reg [31:0] cfg_d;
  reg aw_hold_q;
  reg w_hold_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire [31:0] status_w;
  wire tach_pol;
  wire do_write;
  wire [4:0] sel_code;
  wire [19:0] lut_rate;
  wire lut_unlim;
  wire [7:0] wa;
  wire [31:0] wd;
  wire [3:0] ws;

  function [31:0] strb_merge;
    input [31:0] old;
    input [31:0] neu;
    input [3:0] strb;
    integer i;
    begin
      strb_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          strb_merge[i*8 +: 8] = neu[i*8 +: 8];
        end
      end
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `CLCFG_OFF_CFG1) || (a == `CLCFG_OFF_STATUS);
    end
  endfunction

  // back-emf cutoff gates the tach only when the policy bit asks for it
  function tach_gate;
    input run;
    input policy;
    input low;
    begin
      tach_gate = run && (!policy || !low);
    end
  endfunction

  function [5:0] cutoff_mv;
    input [2:0] code;
    begin
      case (code)
        3'h0: cutoff_mv = 6'h01;
        3'h1: cutoff_mv = 6'h02;
        3'h2: cutoff_mv = 6'h05;
        3'h3: cutoff_mv = 6'h0A;
        3'h4: cutoff_mv = 6'h14;
        3'h5: cutoff_mv = 6'h1E;
        default: cutoff_mv = 6'h00;
      endcase
    end
  endfunction

  // =====================================================
  // axi4-lite write: address and data taken in either order
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
  assign wa = aw_hold_q ? awaddr_q : s_axi_awaddr;
  assign wd = w_hold_q ? wdata_q : s_axi_wdata;
  assign ws = w_hold_q ? wstrb_q : s_axi_wstrb;
  assign do_write = (aw_hold_q || (s_axi_awvalid && s_axi_awready)) &&
                    (w_hold_q || (s_axi_wvalid && s_axi_wready));

  always @* begin
    cfg_d = cfg_q;
    if (do_write && wa == `CLCFG_OFF_CFG1) begin
      cfg_d = strb_merge(cfg_q, wd, ws);
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      cfg_q <= `CLCFG_RESET_VAL;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CLCFG_RESP_OKAY;
    end else begin
      cfg_q <= cfg_d;
      if (do_write) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wa == `CLCFG_OFF_CFG1) ? `CLCFG_RESP_OKAY :
                       `CLCFG_RESP_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_hold_q <= 1'b1;
          awaddr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_hold_q <= 1'b1;
          wdata_q <= s_axi_wdata;
          wstrb_q <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // =====================================================
  // axi4-lite read: one cycle after address
  // status is read-only so software can see what the core acts on
  assign s_axi_arready = !s_axi_rvalid;
  assign status_w = {24'h000000, 2'h0, outputs_hiz, low_side_brake,
                     tach_enable, freq_reserved, cutoff_reserved,
                     decel_unlimited};

  always @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CLCFG_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? `CLCFG_RESP_OKAY :
                     `CLCFG_RESP_SLVERR;
      if (s_axi_araddr == `CLCFG_OFF_CFG1) begin
        s_axi_rdata <= cfg_q;
      end else if (s_axi_araddr == `CLCFG_OFF_STATUS) begin
        s_axi_rdata <= status_w;
      end else begin
        s_axi_rdata <= 32'h00000000;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // =====================================================
  // rate decode: source bit picks which 5-bit field feeds the table
  assign sel_code = cfg_q[`CLCFG_SRC_BIT] ?
                    cfg_q[`CLCFG_ACC_HI:`CLCFG_ACC_LO] :
                    cfg_q[`CLCFG_DEC_HI:`CLCFG_DEC_LO];

  clcfg_rate_lut u_lut (
    .code(sel_code),
    .rate_x10(lut_rate),
    .unlimited(lut_unlim)
  );

  // =====================================================
  // decoded outputs, registered one cycle behind the store
  always @(posedge mclk) begin
    if (!rst_n) begin
      decel_rate_x10 <= 20'h00000;
      decel_unlimited <= 1'b0;
    end else begin
      // surge protection owns the decel profile when enabled with the source bit zero
      if (cfg_q[`CLCFG_SURGE_BIT] && !cfg_q[`CLCFG_SRC_BIT]) begin
        decel_rate_x10 <= 20'h00000;
        decel_unlimited <= 1'b0;
      end else begin
        decel_rate_x10 <= lut_rate;
        decel_unlimited <= lut_unlim;
      end
    end
  end

  // =====================================================
  // switching frequency and modulation
  always @(posedge mclk) begin
    if (!rst_n) begin
      output_switching_freq_khz <= 8'h00;
      freq_reserved <= 1'b0;
      discontinuous_svm <= 1'b0;
    end else begin
      if (cfg_q[`CLCFG_FREQ_HI:`CLCFG_FREQ_LO] > `CLCFG_FREQ_MAX) begin
        output_switching_freq_khz <= 8'h00;
        freq_reserved <= 1'b1;
      end else begin
        output_switching_freq_khz <= `CLCFG_FREQ_BASE + `CLCFG_FREQ_STEP *
          {4'h0, cfg_q[`CLCFG_FREQ_HI:`CLCFG_FREQ_LO]};
        freq_reserved <= 1'b0;
      end
      discontinuous_svm <= cfg_q[`CLCFG_MOD_BIT];
    end
  end

  // =====================================================
  // tachometer output
  assign tach_pol = cfg_q[`CLCFG_TPOL_BIT];
  always @(posedge mclk) begin
    if (!rst_n) begin
      tach_enable <= 1'b0;
      tach_divide_by <= 4'h0;
      tach_backemf_cutoff_mv <= 6'h00;
      cutoff_reserved <= 1'b0;
    end else begin
      case (cfg_q[`CLCFG_TSEL_HI:`CLCFG_TSEL_LO])
        2'h0: tach_enable <= tach_gate(motor_driven, tach_pol, backemf_low);
        2'h1: tach_enable <= closed_loop_phase &&
          tach_gate(motor_driven, tach_pol, backemf_low);
        2'h2: tach_enable <= !closed_loop_phase && first_attempt &&
          tach_gate(motor_driven, tach_pol, backemf_low);
        default: tach_enable <= 1'b0;
      endcase
      // divide-by-zero is meaningless, so code 0 aliases code 1
      tach_divide_by <= (cfg_q[`CLCFG_TDIV_HI:`CLCFG_TDIV_LO] == 4'h0) ?
        4'h1 : cfg_q[`CLCFG_TDIV_HI:`CLCFG_TDIV_LO];
      tach_backemf_cutoff_mv <=
        cutoff_mv(cfg_q[`CLCFG_BEMF_HI:`CLCFG_BEMF_LO]);
      cutoff_reserved <= cfg_q[`CLCFG_BEMF_HI:`CLCFG_BEMF_LO] >
                         `CLCFG_BEMF_MAX;
    end
  end

  // =====================================================
  // loop options and slow-speed stop
  always @(posedge mclk) begin
    if (!rst_n) begin
      surge_protect_enable <= 1'b0;
      deadtime_comp_enable <= 1'b0;
      velocity_loop_run <= 1'b0;
      outputs_hiz <= 1'b0;
      low_side_brake <= 1'b0;
    end else begin
      surge_protect_enable <= cfg_q[`CLCFG_SURGE_BIT];
      deadtime_comp_enable <= cfg_q[`CLCFG_DTC_BIT];
      velocity_loop_run <= !cfg_q[`CLCFG_VLD_BIT];
      if (stop_mode == `CLCFG_STOP_RECIRC && slow_phase) begin
        outputs_hiz <= !cfg_q[`CLCFG_BRK_BIT];
        low_side_brake <= cfg_q[`CLCFG_BRK_BIT];
      end else begin
        outputs_hiz <= 1'b0;
        low_side_brake <= 1'b0;
      end
    end
  end
endmodule // clcfg_top

// ==== tb/clcfg_chk_sva.sv ====
`timescale 1ns/1ps
// ========================================
// port checks for the config decoder
module clcfg_chk (
  input wire mclk,
  input wire rst_n,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire [2:0] stop_mode,
  input wire slow_phase,
  input wire motor_driven,
  input wire [19:0] decel_rate_x10,
  input wire decel_unlimited,
  input wire [7:0] output_switching_freq_khz,
  input wire freq_reserved,
  input wire tach_enable,
  input wire [3:0] tach_divide_by,
  input wire outputs_hiz,
  input wire low_side_brake
);
  wire [7:0] fk = output_switching_freq_khz;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_aw;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_ar;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr; s_aw |=> s_axi_bvalid; endproperty
  a_wr: assert property (p_wr) else $error("no write resp");
  property p_bb; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_bb: assert property (p_bb) else $error("taken in resp");
  property p_rd; s_ar |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("no read data");
  property p_unl; decel_unlimited |-> decel_rate_x10 == 20'h0; endproperty
  a_unl: assert property (p_unl) else $error("bad no-limit");
  // first edge after release still shows the reset zeros
  property p_frq; $past(rst_n) |-> (freq_reserved ? fk == 8'h00 :
    (fk >= 8'h0A && fk <= 8'h4B && fk % 8'h05 == 8'h00)); endproperty
  a_frq: assert property (p_frq) else $error("bad freq");
  property p_div; $past(rst_n) |-> tach_divide_by != 4'h0; endproperty
  a_div: assert property (p_div) else $error("bad divider");
  property p_brk; stop_mode != 3'h1 || !slow_phase |=>
    !outputs_hiz && !low_side_brake; endproperty
  a_brk: assert property (p_brk) else $error("stray brake");
  property p_tch; !motor_driven |=> !tach_enable; endproperty
  a_tch: assert property (p_tch) else $error("tach idle on");
endmodule // clcfg_chk

bind clcfg_top clcfg_chk clcfg_chk_i (.mclk, .rst_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .stop_mode, .slow_phase,
  .motor_driven, .decel_rate_x10, .decel_unlimited,
  .output_switching_freq_khz, .freq_reserved, .tach_enable,
  .tach_divide_by, .outputs_hiz, .low_side_brake);

// ==== tb/clcfg_top_tb.sv ====
`timescale 1ns/1ps
// ========================================
// bench for the config decoder
module clcfg_top_tb;
  logic mclk = 1'h0, rst_n = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, slow_phase = 1'h0;
  logic [2:0] stop_mode = 3'h0;
  logic closed_loop_phase = 1'h0, first_attempt = 1'h0;
  logic motor_driven = 1'h0, backemf_low = 1'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, decel_unlimited, freq_reserved, discontinuous_svm;
  wire tach_enable, cutoff_reserved, surge_protect_enable, outputs_hiz;
  wire deadtime_comp_enable, velocity_loop_run, low_side_brake;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [19:0] decel_rate_x10;
  wire [7:0] output_switching_freq_khz;
  wire [3:0] tach_divide_by;
  wire [5:0] tach_backemf_cutoff_mv;
  wire [23:0] outs = {output_switching_freq_khz, freq_reserved,
    discontinuous_svm, tach_divide_by, tach_backemf_cutoff_mv,
    cutoff_reserved, surge_protect_enable, deadtime_comp_enable,
    velocity_loop_run};
  logic [5:0] mvt [8] = '{6'h01, 6'h02, 6'h05, 6'h0A, 6'h14, 6'h1E,
    6'h00, 6'h00};
  logic [31:0] rv, cv;
  logic [23:0] ev;
  logic [1:0] rs;
  logic [3:0] n;
  logic tk, ta, tw;
  int errors = 0, checks = 0, k, j;
  clcfg_top clcfg_top_i (.mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stop_mode, .slow_phase,
    .closed_loop_phase, .first_attempt, .motor_driven, .backemf_low,
    .decel_rate_x10, .decel_unlimited, .output_switching_freq_khz,
    .freq_reserved, .discontinuous_svm, .tach_enable, .tach_divide_by,
    .tach_backemf_cutoff_mv, .cutoff_reserved, .surge_protect_enable,
    .deadtime_comp_enable, .velocity_loop_run, .outputs_hiz,
    .low_side_brake);
  // ========================================
  // bus and compare helpers
  task chk(input [39:0] g, input [39:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // readies are sampled mid-cycle, where the combinational path is settled
  task wr(input [7:0] a, input [31:0] d, input [3:0] s);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    tk = 1'h0;
    while (!tk) begin
      @(negedge mclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tk = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge mclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
  endtask
  task rd(input [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    tk = 1'h0;
    while (!tk) begin
      @(negedge mclk);
      ta = s_axi_arready;
      tk = s_axi_rvalid;
      rv = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge mclk);
      if (ta) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
  endtask
  task st;
    repeat (2) @(negedge mclk);
  endtask
  function [23:0] ef(input [3:0] i);
    ef = {(i < 4'hE ? 8'h0A + 8'h05 * i : 8'h00), i > 4'hD, i[0],
      (i < 4'h2 ? 4'h1 : i), mvt[i[2:0]], i[2:0] > 3'h5, i[3:2], !i[1]};
  endfunction
  // ========================================
  // scenarios
  task t_bus;
    rd(8'h88);
    chk({rs, rv}, 34'h0);
    chk(outs, ef(4'h0));
    wr(8'h88, 32'hFFFFFFFF, 4'h2);
    wr(8'h90, 32'hFFFFFFFF, 4'hF);
    chk(rs, 2'h2);
    rd(8'h88);
    chk({rs, rv}, 34'h0000FF00);
    rd(8'h40);
    chk({rs, rv}, {2'h2, 32'h0});
    $display("done bus");
  endtask
  task t_fields;
    for (k = 0; k < 16; k++) begin
      n = k[3:0];
      cv = {13'h0, n, n[0], 2'h0, n, 1'h0, n[2:0], n[3:1], 1'h0};
      wr(8'h88, cv, 4'hF);
      st;
      ev = ef(n);
      chk(outs[23:10], ev[23:10]);
      chk(outs[9:0], ev[9:0]);
      rd(8'h88);
      chk({rs, rv}, {2'h0, cv});
      // status: freq reserved bit 2, cutoff reserved bit 1
      ev[2:0] = {n > 4'hD, n[2:0] > 3'h5, 1'h0};
      rd(8'h90);
      chk({rs, rv}, {2'h0, 29'h0, ev[2:0]});
    end
    $display("done fields");
  endtask
  task dc(input [31:0] d, input [20:0] e);
    wr(8'h88, d, 4'hF);
    st;
    chk({decel_unlimited, decel_rate_x10}, e);
  endtask
  task t_dec;
    dc(32'h0, 21'h5);
    dc(32'h00980000, 21'h2710);
    dc(32'h00F00000, 21'hAAE60);
    dc(32'h00F80000, 21'h100000);
    rd(8'h90);
    chk({rs, rv}, 34'h1);
    dc(32'h00F80008, 21'h0);
    dc(32'h05F80000, 21'h19);
    dc(32'h05F80008, 21'h19);
    $display("done decel");
  endtask
  task t_tach;
    for (k = 0; k < 8; k++) begin
      wr(8'h88, {18'h0, k[1:0], 4'h0, k[2], 7'h0}, 4'hF);
      for (j = 0; j < 16; j++) begin
        @(posedge mclk);
        {backemf_low, motor_driven, first_attempt, closed_loop_phase} <=
          j[3:0];
        st;
        tk = k[1:0] == 2'h0 || (k[1:0] == 2'h1 && j[0]) ||
          (k[1:0] == 2'h2 && !j[0] && j[1]);
        chk(tach_enable, tk && j[2] && !(k[2] && j[3]));
      end
    end
    $display("done tach");
  endtask
  task t_brake;
    for (k = 0; k < 2; k++) begin
      wr(8'h88, {31'h0, k[0]}, 4'hF);
      for (j = 0; j < 16; j++) begin
        @(posedge mclk);
        {slow_phase, stop_mode} <= j[3:0];
        st;
        tk = j[2:0] == 3'h1 && j[3];
        ev[1:0] = {tk && !k[0], tk && k[0]};
        chk({outputs_hiz, low_side_brake}, ev[1:0]);
      end
    end
    $display("done brake");
  endtask
  // mid-run reset must clear a fully written register
  task t_rst;
    wr(8'h88, 32'hFFFFFFFF, 4'hF);
    @(posedge mclk);
    rst_n <= 1'h0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'h1;
    st;
    chk(outs, ef(4'h0));
    chk({decel_unlimited, decel_rate_x10}, 21'h5);
    rd(8'h88);
    chk({rs, rv}, 34'h0);
    $display("done reset");
  endtask
  task final_report;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial forever #12.5 mclk = ~mclk;
  // whole run is well under 2000 cycles
  initial begin
    repeat (5000) @(posedge mclk);
    errors++;
    final_report;
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'h1;
    t_bus;
    t_fields;
    t_dec;
    t_tach;
    t_brake;
    t_rst;
    final_report;
  end
endmodule // clcfg_top_tb
